/* common/pcs_pkg.sv */
// Shared constants, register map and types for the position command scaler.
package pcs_pkg;
  // Clock rate and the smoothing time unit, with the derived cycle count.
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned SMOOTH_UNIT_MS  = 10;
  localparam int unsigned SMOOTH_UNIT_CYC = CLK_HZ / 1000 * SMOOTH_UNIT_MS;
  localparam int unsigned NUM_TARGETS     = 8;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_SMOOTH = 16'h0108;
  localparam logic [15:0] IDX_NUM1   = 16'h012c;
  localparam logic [15:0] IDX_DEN    = 16'h012d;
  localparam logic [15:0] IDX_KPP    = 16'h0200;
  localparam logic [15:0] IDX_FF     = 16'h0202;
  localparam logic [15:0] IDX_NUMX   = 16'h0260;
  localparam logic [15:0] IDX_CTRL   = 16'h0300;
  localparam logic [15:0] IDX_STAT   = 16'h0301;
  localparam logic [15:0] IDX_RAWPOS = 16'h0302;
  localparam logic [15:0] IDX_FILPOS = 16'h0303;
  localparam logic [15:0] IDX_TGT    = 16'h0310;

  // Reset values.
  localparam logic [15:0] SMOOTH_RST = 16'h0000;
  localparam logic [15:0] NUM_RST    = 16'h0001;
  localparam logic [15:0] DEN_RST    = 16'h0001;
  localparam logic [15:0] KPP_RST    = 16'h0023;
  localparam logic [15:0] FF_RST     = 16'h1388;
  localparam logic [2:0]  CTRL_RST   = 3'h0;

  // Legal ranges; writes outside them are clamped.
  localparam logic [15:0] NUM_MIN    = 16'h0001;
  localparam logic [15:0] NUM_MAX    = 16'h7fff;
  localparam logic [15:0] SMOOTH_MAX = 16'h03e8;
  localparam logic [15:0] KPP_MAX    = 16'h03ff;
  localparam logic [15:0] FF_MIN     = 16'h000a;
  localparam logic [15:0] FF_MAX     = 16'h4e20;

  // Field positions in the control and status registers.
  localparam int CTRL_MODE_BIT  = 0;
  localparam int CTRL_NSEL_LSB  = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SERVO_BIT = 1;

  // Feed-forward gain is in units of 1/10000; 6711 / 2^26 approximates that.
  localparam int FF_MUL   = 6711;
  localparam int FF_SHIFT = 26;

  // Internal move sequencer states.
  typedef enum logic [1:0] {
    PCS_MV_IDLE = 2'b01,
    PCS_MV_RUN  = 2'b10
  } pcs_mv_t;
endpackage : pcs_pkg

/* rtl/pcs_cmd_smoother.sv */
// First-order low-pass smoothing of the scaled position command.
`timescale 1ns/100ps
module pcs_cmd_smoother #(
  parameter int unsigned UNIT_CYC = pcs_pkg::SMOOTH_UNIT_CYC // Cycles per time unit.
) (
  input  logic        ref_clk, // System clock.
  input  logic        resetn,  // Asynchronous reset, active low.
  input  logic [15:0] tau,     // Time constant in units; zero bypasses.
  input  logic [31:0] cmd_in,  // Scaled command, signed.
  output logic [31:0] cmd_out  // Smoothed command, signed.
);
  localparam int unsigned TW = $clog2(UNIT_CYC + 1);

  logic [TW-1:0]      tick_cnt_q; // Time unit prescaler.
  logic               tick;       // One cycle per time unit.
  logic signed [39:0] acc_q;      // Error integrated but not yet applied.
  logic signed [39:0] acc_d;
  logic [31:0]        out_q;      // Filter state.
  logic [31:0]        out_d;
  logic signed [39:0] err_w;      // Input minus output.
  logic signed [39:0] tau_s;      // Time constant as signed divisor.

  assign tick  = (tick_cnt_q == TW'(UNIT_CYC - 1));
  assign err_w = 40'($signed(cmd_in)) - 40'($signed(out_q));
  assign tau_s = 40'($signed({1'b0, tau}));
  assign cmd_out = out_q;

  // The prescaler runs freely so the filter step is evenly spaced.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // Each time unit adds error/tau to the output; the division is done by
  // draining the accumulator one count per cycle, which avoids a divider.
  always_comb begin
    acc_d = acc_q;
    out_d = out_q;
    if (tau == 16'h0000) begin
      acc_d = '0;
      out_d = cmd_in; // R13
    end else begin
      if (acc_q >= tau_s) begin
        acc_d = acc_q - tau_s; // R13
        out_d = out_q + 32'h1;
      end else if (acc_q <= -tau_s) begin
        acc_d = acc_q + tau_s;
        out_d = out_q - 32'h1;
      end
      if (tick) begin
        acc_d = acc_d + err_w;
      end
    end
  end

  // Filter state update.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= '0;
      out_q <= '0;
    end else begin
      acc_q <= acc_d;
      out_q <= out_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_smooth_bypass: assert property ( // R13
    (tau == 16'h0000) |=> (cmd_out == $past(cmd_in))
  ) else $error("Disabled smoothing did not pass the command through.");

  chk_smooth_slew: assert property ( // R13
    (tau != 16'h0000) |=> (cmd_out == $past(cmd_out) || cmd_out == $past(cmd_out) + 32'h1
                           || cmd_out == $past(cmd_out) - 32'h1)
  ) else $error("Smoothed command moved by more than one count in a cycle.");
endmodule : pcs_cmd_smoother

/* rtl/pcs_position_command_scaler.sv */
// Position command scaler: gearing, target moves, smoothing and position loop.
// Function
// R1: primary numerator 1 to 32767, reset 1
// R2: one denominator 1 to 32767, reset 1
// R3: command equals pulse count times numerator/denominator
// R4: numerator chosen from four stored values
// R5: software keeps ratio between 1/50 and 200
// R6: software changes gear only with drive off
// R7: smoothing constant 0 to 1000, zero disables
// R8: select inputs pick target, trigger starts move
// R9: position loop gain 0 to 1023
// R10: feed-forward gain 10 to 20000, 0.0001 units
// R11: software keeps position bandwidth under speed/4
// R12: software tunes speed loop before position loop
// R13: first-order low-pass, bypassed when disabled
`timescale 1ns/100ps
module pcs_position_command_scaler #(
  parameter int unsigned SMOOTH_UNIT_CYC = pcs_pkg::SMOOTH_UNIT_CYC // Cycles per 10 ms.
) (
  input  logic        ref_clk,              // System clock, 125 MHz.
  input  logic        resetn,               // Asynchronous reset, active low.
  input  logic        psel,                 // APB select.
  input  logic        penable,              // APB enable.
  input  logic        pwrite,               // APB write.
  input  logic [15:0] paddr,                // APB byte address.
  input  logic [31:0] pwdata,               // APB write data.
  output logic [31:0] prdata,               // APB read data.
  output logic        pready,               // APB ready.
  output logic        pslverr,              // APB error on unmapped address.
  input  logic        cmd_pulse,            // Command pulse pin, counts on rise.
  input  logic        cmd_dir,              // Direction pin, high is reverse.
  input  logic [2:0]  target_select_inputs, // Target select pins.
  input  logic        command_trigger,      // Move start pin, acts on rise.
  input  logic        servo_on,             // Drive output enabled.
  input  logic [31:0] feedback_pos,         // Measured position, signed.
  output logic [31:0] position_command,     // Smoothed command, signed.
  output logic [31:0] speed_cmd             // Position loop output, signed.
);
  // Index match on the word address bits.
  function automatic logic at_idx(input logic [15:0] a, input logic [15:0] idx);
    return a[15:2] == idx[13:0];
  endfunction : at_idx

  // Clamp a written value into a legal range.
  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < {16'h0000, lo}) begin
      return lo;
    end else if (v > {16'h0000, hi}) begin
      return hi;
    end
    return v[15:0];
  endfunction : clamp16

  // Pin synchronisers and edge history.
  logic [6:0]  pin_s1_q;   // First stage, read only by the second.
  logic [6:0]  pin_s2_q;   // Second stage.
  logic        pulse_s3_q; // Delayed pulse for edge detect.
  logic        trig_s3_q;  // Delayed trigger for edge detect.
  logic        pulse_rise; // Command pulse edge.
  logic        trig_rise;  // Trigger edge.
  logic        dir_s;      // Synchronised direction.
  logic [2:0]  sel_s;      // Synchronised target select.
  logic        servo_s;    // Synchronised drive enable.

  // Registers.
  logic [15:0] smooth_q;               // Smoothing constant.
  logic [15:0] num_q [4];              // Entry 0 is the primary numerator.
  logic [15:0] den_q;                  // Gear denominator.
  logic [15:0] kpp_q;                  // Position loop gain.
  logic [15:0] ff_q;                   // Feed-forward gain.
  logic [2:0]  ctrl_q;                 // Mode and numerator select.
  logic [31:0] tgt_q [pcs_pkg::NUM_TARGETS]; // Stored move lengths.
  logic [31:0] prdata_q;               // Read data captured in setup.

  // Bus decode.
  logic        wr_en;   // Write takes effect this edge.
  logic        tgt_hit; // Address falls in the target block.
  logic        hit;     // Address is mapped.
  logic [31:0] rd_d;    // Read data for the current address.

  // Gearing and moves.
  logic [1:0]          nsel;      // Selected numerator.
  logic [15:0]         num_used;  // Numerator in use.
  logic signed [39:0]  num_s;     // Numerator as signed step.
  logic signed [39:0]  den_s;     // Denominator as signed step.
  logic signed [39:0]  rem_q;     // Scaled pulses not yet output.
  logic signed [39:0]  rem_d;
  logic [31:0]         raw_pos_q; // Geared command before smoothing.
  logic [31:0]         raw_pos_d;
  logic                step_en;   // One input pulse this cycle.
  logic                step_neg;  // That pulse is reverse.
  pcs_pkg::pcs_mv_t    mv_q;      // Move sequencer state.
  logic signed [31:0]  remain_q;  // Pulses left in the current move.
  logic [31:0]         tgt_pick;  // Target addressed by the select pins.
  logic                int_mode;  // Internal target mode.

  // Position loop.
  logic [31:0]         filt_prev_q; // Command one cycle ago.
  logic signed [63:0]  p_term;      // Proportional term.
  logic signed [63:0]  f_term;      // Feed-forward term.
  logic [31:0]         speed_q;     // Loop output.

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
    end else begin
      pin_s1_q <= {servo_on, command_trigger, target_select_inputs, cmd_dir, cmd_pulse};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign dir_s   = pin_s2_q[1];
  assign sel_s   = pin_s2_q[4:2];
  assign servo_s = pin_s2_q[6];

  // Edge history is taken from the second stage only.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_s3_q <= 1'b0;
      trig_s3_q  <= 1'b0;
    end else begin
      pulse_s3_q <= pin_s2_q[0];
      trig_s3_q  <= pin_s2_q[5];
    end
  end

  assign pulse_rise = pin_s2_q[0] & ~pulse_s3_q;
  assign trig_rise  = pin_s2_q[5] & ~trig_s3_q;

  // APB decode; the slave never waits, so pready stays high.
  assign wr_en   = psel & penable & pwrite;
  assign tgt_hit = (paddr[15:5] == pcs_pkg::IDX_TGT[13:3]);
  assign hit     = at_idx(paddr, pcs_pkg::IDX_SMOOTH) | at_idx(paddr, pcs_pkg::IDX_NUM1)
                 | at_idx(paddr, pcs_pkg::IDX_DEN) | at_idx(paddr, pcs_pkg::IDX_KPP)
                 | at_idx(paddr, pcs_pkg::IDX_FF) | at_idx(paddr, pcs_pkg::IDX_CTRL)
                 | at_idx(paddr, pcs_pkg::IDX_STAT) | at_idx(paddr, pcs_pkg::IDX_RAWPOS)
                 | at_idx(paddr, pcs_pkg::IDX_FILPOS) | tgt_hit
                 | (paddr[15:4] == pcs_pkg::IDX_NUMX[13:2] && paddr[3:2] != 2'b11);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_q;

  // Read multiplexer; narrow registers read with zeros above.
  always_comb begin
    rd_d = 32'h0000_0000;
    if (at_idx(paddr, pcs_pkg::IDX_SMOOTH)) begin
      rd_d = {16'h0000, smooth_q};
    end else if (at_idx(paddr, pcs_pkg::IDX_NUM1)) begin
      rd_d = {16'h0000, num_q[0]};
    end else if (at_idx(paddr, pcs_pkg::IDX_DEN)) begin
      rd_d = {16'h0000, den_q};
    end else if (at_idx(paddr, pcs_pkg::IDX_KPP)) begin
      rd_d = {16'h0000, kpp_q};
    end else if (at_idx(paddr, pcs_pkg::IDX_FF)) begin
      rd_d = {16'h0000, ff_q};
    end else if (paddr[15:4] == pcs_pkg::IDX_NUMX[13:2] && paddr[3:2] != 2'b11) begin
      rd_d = {16'h0000, num_q[paddr[3:2] + 2'd1]};
    end else if (at_idx(paddr, pcs_pkg::IDX_CTRL)) begin
      rd_d = {29'h0, ctrl_q};
    end else if (at_idx(paddr, pcs_pkg::IDX_STAT)) begin
      rd_d = 32'h0000_0000;
      rd_d[pcs_pkg::STAT_BUSY_BIT]  = (mv_q == pcs_pkg::PCS_MV_RUN);
      rd_d[pcs_pkg::STAT_SERVO_BIT] = servo_s;
    end else if (at_idx(paddr, pcs_pkg::IDX_RAWPOS)) begin
      rd_d = raw_pos_q;
    end else if (at_idx(paddr, pcs_pkg::IDX_FILPOS)) begin
      rd_d = position_command;
    end else if (tgt_hit) begin
      rd_d = tgt_q[paddr[4:2]];
    end
  end

  // Read data is captured in the setup cycle so it is a flip-flop output.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_d;
    end
  end

  // Gear registers; writes are ignored while the drive is on, since a ratio
  // change under motion would make the command jump.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      num_q[0] <= pcs_pkg::NUM_RST; // R1
      num_q[1] <= pcs_pkg::NUM_RST;
      num_q[2] <= pcs_pkg::NUM_RST;
      num_q[3] <= pcs_pkg::NUM_RST;
      den_q    <= pcs_pkg::DEN_RST; // R2
    end else if (wr_en && !servo_s) begin // R6
      if (at_idx(paddr, pcs_pkg::IDX_NUM1)) begin
        num_q[0] <= clamp16(pwdata, pcs_pkg::NUM_MIN, pcs_pkg::NUM_MAX); // R1
      end else if (at_idx(paddr, pcs_pkg::IDX_DEN)) begin
        den_q <= clamp16(pwdata, pcs_pkg::NUM_MIN, pcs_pkg::NUM_MAX); // R2
      end else if (paddr[15:4] == pcs_pkg::IDX_NUMX[13:2] && paddr[3:2] != 2'b11) begin
        num_q[paddr[3:2] + 2'd1] <= clamp16(pwdata, pcs_pkg::NUM_MIN, pcs_pkg::NUM_MAX); // R4
      end
    end
  end

  // Loop and filter settings, writable at any time.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      smooth_q <= pcs_pkg::SMOOTH_RST;
      kpp_q    <= pcs_pkg::KPP_RST;
      ff_q     <= pcs_pkg::FF_RST;
      ctrl_q   <= pcs_pkg::CTRL_RST;
    end else if (wr_en) begin
      if (at_idx(paddr, pcs_pkg::IDX_SMOOTH)) begin
        smooth_q <= clamp16(pwdata, 16'h0000, pcs_pkg::SMOOTH_MAX); // R7
      end else if (at_idx(paddr, pcs_pkg::IDX_KPP)) begin
        kpp_q <= clamp16(pwdata, 16'h0000, pcs_pkg::KPP_MAX); // R9
      end else if (at_idx(paddr, pcs_pkg::IDX_FF)) begin
        ff_q <= clamp16(pwdata, pcs_pkg::FF_MIN, pcs_pkg::FF_MAX); // R10
      end else if (at_idx(paddr, pcs_pkg::IDX_CTRL)) begin
        ctrl_q <= pwdata[2:0];
      end
    end
  end

  // Target table, one word per select code.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < pcs_pkg::NUM_TARGETS; i++) begin
        tgt_q[i] <= 32'h0000_0000;
      end
    end else if (wr_en && tgt_hit) begin
      tgt_q[paddr[4:2]] <= pwdata;
    end
  end

  assign int_mode = ctrl_q[pcs_pkg::CTRL_MODE_BIT];
  assign nsel     = ctrl_q[pcs_pkg::CTRL_NSEL_LSB +: 2];
  assign num_used = num_q[nsel]; // R4
  assign tgt_pick = tgt_q[sel_s]; // R8

  // Internal moves: a trigger edge loads the selected length, then one
  // pulse per cycle is fed to the gear until it is used up.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mv_q     <= pcs_pkg::PCS_MV_IDLE;
      remain_q <= 32'sh0;
    end else begin
      unique case (mv_q)
        pcs_pkg::PCS_MV_IDLE: begin
          if (int_mode && trig_rise) begin // R8
            remain_q <= $signed(tgt_pick);
            mv_q     <= pcs_pkg::PCS_MV_RUN;
          end
        end
        pcs_pkg::PCS_MV_RUN: begin
          if (remain_q == 32'sh0 || !int_mode) begin
            remain_q <= 32'sh0;
            mv_q     <= pcs_pkg::PCS_MV_IDLE;
          end else if (remain_q > 32'sh0) begin
            remain_q <= remain_q - 32'sh1;
          end else begin
            remain_q <= remain_q + 32'sh1;
          end
        end
        default: begin
          remain_q <= 32'sh0;
          mv_q     <= pcs_pkg::PCS_MV_IDLE;
        end
      endcase
    end
  end

  // Pulse source by mode: the pins outside, the sequencer inside.
  always_comb begin
    if (int_mode) begin
      step_en  = (mv_q == pcs_pkg::PCS_MV_RUN) && (remain_q != 32'sh0);
      step_neg = remain_q < 32'sh0;
    end else begin
      step_en  = pulse_rise;
      step_neg = dir_s;
    end
  end

  assign num_s = 40'($signed({1'b0, num_used}));
  assign den_s = 40'($signed({1'b0, den_q}));

  // Each pulse adds N to the remainder; each cycle that the remainder holds
  // a whole M emits one output count. No divider, but at ratios above one
  // the output lags by up to N/M cycles per pulse.
  always_comb begin
    rem_d     = rem_q;
    raw_pos_d = raw_pos_q;
    if (rem_q >= den_s) begin
      rem_d     = rem_q - den_s; // R3
      raw_pos_d = raw_pos_q + 32'h1;
    end else if (rem_q <= -den_s) begin
      rem_d     = rem_q + den_s;
      raw_pos_d = raw_pos_q - 32'h1;
    end
    if (step_en) begin
      rem_d = step_neg ? rem_d - num_s : rem_d + num_s; // R3
    end
  end

  // Gear state.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rem_q     <= 40'sh0;
      raw_pos_q <= 32'h0000_0000;
    end else begin
      rem_q     <= rem_d;
      raw_pos_q <= raw_pos_d;
    end
  end

  // Smoothing of the geared command.
  pcs_cmd_smoother #(
    .UNIT_CYC (SMOOTH_UNIT_CYC)
  ) u_smoother (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tau     (smooth_q),
    .cmd_in  (raw_pos_q),
    .cmd_out (position_command)
  );

  // Proportional term on the following error plus feed-forward on the
  // command rate; the 1/10000 scale is approximate to avoid a divider.
  assign p_term = 64'($signed(position_command - feedback_pos))
                * 64'($signed({1'b0, kpp_q})); // R9
  assign f_term = (64'($signed(position_command - filt_prev_q))
                * 64'($signed({1'b0, ff_q})) * 64'(pcs_pkg::FF_MUL))
                >>> pcs_pkg::FF_SHIFT; // R10

  // Loop output register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      filt_prev_q <= 32'h0000_0000;
      speed_q     <= 32'h0000_0000;
    end else begin
      filt_prev_q <= position_command;
      speed_q     <= 32'(p_term + f_term);
    end
  end

  assign speed_cmd = speed_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_trig_accept;
    int_mode && trig_rise && mv_q == pcs_pkg::PCS_MV_IDLE;
  endsequence

  sequence s_move_loaded;
    mv_q == pcs_pkg::PCS_MV_RUN && remain_q == $signed($past(tgt_pick));
  endsequence

  chk_num_range: assert property ( // R1
    num_q[0] >= pcs_pkg::NUM_MIN && num_q[0] <= pcs_pkg::NUM_MAX
  ) else $error("Primary numerator left its range.");

  chk_den_range: assert property ( // R2
    den_q >= pcs_pkg::NUM_MIN && den_q <= pcs_pkg::NUM_MAX
  ) else $error("Denominator left its range.");

  chk_gear_drain: assert property ( // R3
    (rem_q >= den_s) |=> (raw_pos_q == $past(raw_pos_q) + 32'h1)
  ) else $error("Whole denominator in remainder did not advance the command.");

  chk_gear_accum: assert property ( // R3
    (step_en && !step_neg && rem_q < den_s && rem_q > -den_s)
      |=> (rem_q == $past(rem_q) + 40'($signed({1'b0, $past(num_used)})))
  ) else $error("Forward pulse did not add the numerator.");

  chk_num_select: assert property ( // R4
    (nsel == 2'd1 && step_en && !step_neg && rem_q < den_s && rem_q > -den_s)
      |=> (rem_q == $past(rem_q) + 40'($signed({1'b0, $past(num_q[1])})))
  ) else $error("Selected numerator was not used.");

  chk_smooth_range: assert property ( // R7
    smooth_q <= pcs_pkg::SMOOTH_MAX
  ) else $error("Smoothing constant left its range.");

  chk_move_start: assert property ( // R8
    s_trig_accept |=> s_move_loaded
  ) else $error("Trigger did not load the selected target.");

  chk_move_ends: assert property ( // R8
    (mv_q == pcs_pkg::PCS_MV_RUN && remain_q == 32'sh0) |=> (mv_q == pcs_pkg::PCS_MV_IDLE)
  ) else $error("Finished move did not return to idle.");

  chk_kpp_range: assert property ( // R9
    kpp_q <= pcs_pkg::KPP_MAX
  ) else $error("Position gain left its range.");

  chk_ff_range: assert property ( // R10
    ff_q >= pcs_pkg::FF_MIN && ff_q <= pcs_pkg::FF_MAX
  ) else $error("Feed-forward gain left its range.");

  chk_gear_locked: assert property ( // R6
    servo_s |=> (num_q[0] == $past(num_q[0]) && den_q == $past(den_q))
  ) else $error("Gear changed while the drive was on.");
endmodule : pcs_position_command_scaler

/* verif/pcs_pulse_master.sv */
// Model of the motion controller that sends command pulses.
`timescale 1ns/100ps
module pcs_pulse_master (
  input  wire logic       ref_clk,   // Clock.
  input  wire logic       go,        // Starts a burst.
  input  wire logic [7:0] npulse,    // Pulse count.
  input  wire logic       rev,       // Reverse burst.
  output logic            cmd_pulse, // Pulse pin.
  output logic            cmd_dir,   // Direction pin.
  output logic            busy       // Burst running.
);
  // Each level lasts 4 cycles, so a pulse period of 8 backs up the gear only at ratios above 8.
  initial begin
    cmd_pulse = 1'b0;
    cmd_dir = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        cmd_dir <= rev;
        repeat (4) @(posedge ref_clk);
        repeat (npulse) begin
          cmd_pulse <= 1'b1;
          repeat (4) @(posedge ref_clk);
          cmd_pulse <= 1'b0;
          repeat (4) @(posedge ref_clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : pcs_pulse_master

/* verif/test_position_command_scaler.sv */
// Self-checking bench for the position command scaler.
`timescale 1ns/100ps
module test_position_command_scaler;
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, feedback_pos = '0, position_command, speed_cmd;
  logic pready, pslverr, cmd_pulse, cmd_dir, command_trigger = 0, go = 0, rev = 0, busy;
  logic servo_on = 0;
  logic [2:0] target_select_inputs = '0;
  logic [7:0] npl = '0, rnd = 8'h3b;
  logic [32:0] q[$];
  int fails, num_checks, pos, rem;
  logic [15:0] ix[5] = '{pcs_pkg::IDX_SMOOTH, pcs_pkg::IDX_NUM1, pcs_pkg::IDX_DEN,
                         pcs_pkg::IDX_KPP, pcs_pkg::IDX_FF};
  logic [15:0] rv[5] = '{pcs_pkg::SMOOTH_RST, pcs_pkg::NUM_RST, pcs_pkg::DEN_RST,
                         pcs_pkg::KPP_RST, pcs_pkg::FF_RST};
  logic [15:0] wv[5] = '{16'h07ff, 16'h8000, 16'h0000, 16'hffff, 16'h5000};
  logic [15:0] cv[5] = '{pcs_pkg::SMOOTH_MAX, pcs_pkg::NUM_MAX, pcs_pkg::NUM_MIN,
                         pcs_pkg::KPP_MAX, pcs_pkg::FF_MAX};

  always #4 ref_clk = ~ref_clk;

  pcs_position_command_scaler #(.SMOOTH_UNIT_CYC(4)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_pulse(cmd_pulse),
    .cmd_dir(cmd_dir), .target_select_inputs(target_select_inputs),
    .command_trigger(command_trigger), .servo_on(servo_on), .feedback_pos(feedback_pos),
    .position_command(position_command), .speed_cmd(speed_cmd));

  pcs_pulse_master host (.ref_clk(ref_clk), .go(go), .npulse(npl), .rev(rev),
    .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .busy(busy));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; a free cycle first keeps psel from being set twice in a step.
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a[13:0], 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(a, 1'b0, '0);
  endtask : rd

  // Reads are compared against the oldest note when the access completes.
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, q.pop_front());

  // Expected gearing with denominator 2 and a signed remainder.
  task automatic gear(input int n, input int nn, input logic r);
    repeat (n) begin
      rem += r ? -nn : nn;
      pos += rem / 2;
      rem = rem % 2;
    end
  endtask : gear

  // Maximal-length 8-bit shift register; the bench seeds it with 59.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic burst(input int nn, input logic r);
    rnd = lfsr(rnd);
    npl <= {5'h0, rnd[2:0]} + 8'h4;
    rev <= r;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    gear(rnd[2:0] + 4, nn, r);
    for (int i = 0; i < 400 && !(i > 1 && busy === 1'b0); i++) @(posedge ref_clk);
    repeat (12) @(posedge ref_clk);
    rd(pcs_pkg::IDX_RAWPOS, {1'b0, 32'(pos)});
  endtask : burst

  task print_verdict;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Watchdog far beyond the few hundred cycles the sequence needs.
  initial begin
    #100000;
    fails++;
    print_verdict;
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (ix[i]) rd(ix[i], {17'h0, rv[i]});
    foreach (ix[i]) begin
      apb(ix[i], 1'b1, {16'h0, wv[i]});
      rd(ix[i], {17'h0, cv[i]});
    end
    rd(16'h0001, {1'b1, 32'h0});
    // With the drive on, a gear write must leave the numerator untouched.
    servo_on <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(pcs_pkg::IDX_NUM1, 1'b1, 32'h7);
    rd(pcs_pkg::IDX_NUM1, {17'h0, pcs_pkg::NUM_MAX});
    rd(pcs_pkg::IDX_STAT, {1'b0, 32'h1 << pcs_pkg::STAT_SERVO_BIT});
    servo_on <= 1'b0;
    repeat (3) @(posedge ref_clk);
    apb(pcs_pkg::IDX_SMOOTH, 1'b1, 32'h0);
    apb(pcs_pkg::IDX_NUM1, 1'b1, 32'h1);
    apb(pcs_pkg::IDX_DEN, 1'b1, 32'h2);
    burst(1, 1'b0);
    chk({1'b0, position_command}, {1'b0, 32'(pos)});
    apb(pcs_pkg::IDX_NUMX, 1'b1, 32'h3);
    apb(pcs_pkg::IDX_CTRL, 1'b1, 32'h2);
    burst(3, 1'b0);
    burst(3, 1'b1);
    apb(pcs_pkg::IDX_CTRL, 1'b1, 32'h1);
    apb(pcs_pkg::IDX_TGT + 16'h3, 1'b1, 32'h5);
    target_select_inputs <= 3'h3;
    repeat (4) @(posedge ref_clk);
    command_trigger <= 1'b1;
    repeat (40) @(posedge ref_clk);
    command_trigger <= 1'b0;
    gear(5, 1, 1'b0);
    rd(pcs_pkg::IDX_RAWPOS, {1'b0, 32'(pos)});
    // Position gain for a 20 Hz loop, set once the speed loop is settled.
    apb(pcs_pkg::IDX_KPP, 1'b1, 32'h7d);
    feedback_pos <= {24'h0, rnd};
    repeat (6) @(posedge ref_clk);
    chk({1'b0, speed_cmd}, {1'b0, 32'(125 * (pos - int'(rnd)))});
    print_verdict;
  end
endmodule : test_position_command_scaler
